// [inc/pfsa_pkg.sv]
// Package for the program flash self-access block: constants, types, functions
package pfsa_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int PTR_W     = 22;
    localparam int ADDR_W    = 21;
    localparam int CFG_BIT   = 21;
    localparam int HOLD_N    = 8;
    localparam int HOLD_SEL  = 3;
    localparam int ROW_LSB   = 6;
    localparam int BLK_LSB   = 3;
    localparam int ROW_BYTES = 64;
    localparam int WORD_W    = 16;
    localparam int MEM_WORDS = 4096;
    localparam int MEM_AW    = 12;

    // ************************************************************
    // Unlock and timing
    // ************************************************************
    localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'haa;
    localparam logic [7:0] ERASED_BYTE   = 8'hff;
    localparam int CLK_HZ      = 50000000;
    localparam int LONG_WR_US  = 2000;
    localparam int LONG_WR_CYC = (CLK_HZ / 1000000) * LONG_WR_US;
    localparam int TMR_W       = 32;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        PFSA_PTR_KEEP,
        PFSA_PTR_POST_INC,
        PFSA_PTR_POST_DEC,
        PFSA_PTR_PRE_INC
    } pfsa_ptr_mode_e;

    typedef enum logic [1:0] {
        PFSA_UNLOCK_IDLE,
        PFSA_UNLOCK_HALF,
        PFSA_UNLOCK_ARMED
    } pfsa_unlock_e;

    typedef enum logic [0:0] {
        PFSA_RUN,
        PFSA_LONG_WRITE
    } pfsa_seq_e;

    // Step low 21 bits only; the configuration-space bit is kept
    function automatic logic [PTR_W-1:0] pfsa_step(input logic [PTR_W-1:0] p,
                                                   input logic             up);
        logic [ADDR_W-1:0] lo;
        lo = up ? p[ADDR_W-1:0] + 1'b1 : p[ADDR_W-1:0] - 1'b1;
        return {p[CFG_BIT], lo};
    endfunction : pfsa_step

endpackage : pfsa_pkg

// [inc/pfsa_if.sv]
// Interface joining the processor core and the program flash self-access block
`timescale 1ns/1ps
interface pfsa_if;
    import pfsa_pkg::*;
    logic                 tbl_rd;
    logic                 tbl_wr;
    pfsa_ptr_mode_e       ptr_mode;
    logic                 ptr_load;
    logic [PTR_W-1:0]     ptr_load_val;
    logic [7:0]           tbl_wdata;
    logic [PTR_W-1:0]     flash_byte_pointer;
    logic [7:0]           table_byte_latch;
    logic                 ctrl_wr;
    logic                 program_space_select;
    logic                 config_space_select;
    logic                 row_erase_select;
    logic                 write_permit;
    logic                 start_set;
    logic                 unlock_wr;
    logic [7:0]           unlock_data;
    logic                 start_program_bit;
    logic                 aborted_write_flag;
    logic                 done_irq_flag;
    logic                 done_irq_clr;
    logic                 core_stall;
    logic                 abort_rst;

    modport device (
        input  tbl_rd, tbl_wr, ptr_mode, ptr_load, ptr_load_val, tbl_wdata,
        input  ctrl_wr, program_space_select, config_space_select, row_erase_select,
        input  write_permit, start_set, unlock_wr, unlock_data, done_irq_clr, abort_rst,
        output flash_byte_pointer, table_byte_latch, start_program_bit,
        output aborted_write_flag, done_irq_flag, core_stall
    );
    modport core (
        output tbl_rd, tbl_wr, ptr_mode, ptr_load, ptr_load_val, tbl_wdata,
        output ctrl_wr, program_space_select, config_space_select, row_erase_select,
        output write_permit, start_set, unlock_wr, unlock_data, done_irq_clr, abort_rst,
        input  flash_byte_pointer, table_byte_latch, start_program_bit,
        input  aborted_write_flag, done_irq_flag, core_stall
    );
endinterface : pfsa_if

// [design/pfsa_device.sv]
// Program flash self-access device end: table access, row erase, block program
`timescale 1ns/1ps
module pfsa_device
    import pfsa_pkg::*;
#(
    parameter int LONG_CYCLES = LONG_WR_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Core side
    pfsa_if.device   bus
);
    import pfsa_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    logic [WORD_W-1:0]   mem [MEM_WORDS];
    logic [7:0]          hold [HOLD_N];
    logic [PTR_W-1:0]    ptr, next_ptr;
    logic [7:0]          latch, next_latch;
    logic                pgm_sel, next_pgm_sel;
    logic                cfg_sel, next_cfg_sel;
    logic                erase_sel, next_erase_sel;
    logic                permit, next_permit;
    logic                start, next_start;
    logic                abort_flag, next_abort_flag;
    logic                done_flag, next_done_flag;
    pfsa_unlock_e        ulk, next_ulk;
    pfsa_seq_e           seq, next_seq;
    logic [TMR_W-1:0]    tmr, next_tmr;
    logic                commit;
    logic [PTR_W-1:0]    rd_addr;
    logic [WORD_W-1:0]   rd_word;

    function automatic logic [MEM_AW-1:0] word_idx(input logic [PTR_W-1:0] a);
        return a[MEM_AW:1];
    endfunction : word_idx

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        next_ptr        = ptr;
        next_latch      = latch;
        next_pgm_sel    = pgm_sel;
        next_cfg_sel    = cfg_sel;
        next_erase_sel  = erase_sel;
        next_permit     = permit;
        next_start      = start;
        next_abort_flag = abort_flag;
        next_done_flag  = done_flag;
        next_ulk        = ulk;
        next_seq        = seq;
        next_tmr        = tmr;
        commit          = 1'b0;
        rd_addr         = ptr;
        if (bus.ptr_mode == PFSA_PTR_PRE_INC) begin
            rd_addr = pfsa_step(ptr, 1'b1);
        end
        rd_word = mem[word_idx(rd_addr)];
        if (bus.done_irq_clr) begin
            next_done_flag = 1'b0;
        end
        case (seq)
            PFSA_RUN: begin
                if (bus.ptr_load) begin
                    next_ptr = bus.ptr_load_val;
                end else if (bus.tbl_rd || bus.tbl_wr) begin
                    case (bus.ptr_mode)
                        PFSA_PTR_POST_INC: next_ptr = pfsa_step(ptr, 1'b1);
                        PFSA_PTR_POST_DEC: next_ptr = pfsa_step(ptr, 1'b0);
                        PFSA_PTR_PRE_INC:  next_ptr = rd_addr;
                        default:           next_ptr = ptr;
                    endcase
                end
                if (bus.tbl_rd) begin
                    // Config-space reads are not modelled and return zero
                    next_latch = rd_addr[CFG_BIT] ? 8'h00 :
                                 (rd_addr[0] ? rd_word[15:8] : rd_word[7:0]);
                end
                if (bus.ctrl_wr) begin
                    next_pgm_sel   = bus.program_space_select;
                    next_cfg_sel   = bus.config_space_select;
                    next_erase_sel = bus.row_erase_select;
                    next_permit    = bus.write_permit;
                end
                // Any other control write breaks the unlock sequence
                if (bus.unlock_wr) begin
                    if (bus.unlock_data == UNLOCK_FIRST) begin
                        next_ulk = PFSA_UNLOCK_HALF;
                    end else if (bus.unlock_data == UNLOCK_SECOND &&
                                 ulk == PFSA_UNLOCK_HALF) begin
                        next_ulk = PFSA_UNLOCK_ARMED;
                    end else begin
                        next_ulk = PFSA_UNLOCK_IDLE;
                    end
                end else if (bus.start_set) begin
                    next_ulk = PFSA_UNLOCK_IDLE;
                    if (ulk == PFSA_UNLOCK_ARMED && permit) begin
                        next_start = 1'b1;
                        next_seq   = PFSA_LONG_WRITE;
                        next_tmr   = TMR_W'(LONG_CYCLES);
                    end
                end else if (bus.ctrl_wr || bus.tbl_rd || bus.tbl_wr || bus.ptr_load) begin
                    next_ulk = PFSA_UNLOCK_IDLE;
                end
            end
            PFSA_LONG_WRITE: begin
                if (tmr <= TMR_W'(1)) begin
                    commit         = 1'b1;
                    next_start     = 1'b0;
                    next_done_flag = 1'b1;
                    next_erase_sel = 1'b0;
                    next_seq       = PFSA_RUN;
                end else begin
                    next_tmr = tmr - 1'b1;
                end
            end
            default: next_seq = PFSA_RUN;
        endcase
        // Core reset wins over everything; program and config selects and done flag stay for tracing, row erase select clears
        // A commit in the same cycle is dropped so a cut write never lands
        if (bus.abort_rst) begin
            next_ptr        = '0;
            next_latch      = '0;
            next_erase_sel  = 1'b0;
            next_permit     = 1'b0;
            next_start      = 1'b0;
            next_abort_flag = abort_flag | (seq == PFSA_LONG_WRITE);
            next_done_flag  = done_flag;
            next_ulk        = PFSA_UNLOCK_IDLE;
            next_seq        = PFSA_RUN;
            next_tmr        = '0;
            commit          = 1'b0;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ptr        <= '0;
            latch      <= '0;
            pgm_sel    <= 1'b0;
            cfg_sel    <= 1'b0;
            erase_sel  <= 1'b0;
            permit     <= 1'b0;
            start      <= 1'b0;
            abort_flag <= 1'b0;
            done_flag  <= 1'b0;
            ulk        <= PFSA_UNLOCK_IDLE;
            seq        <= PFSA_RUN;
            tmr        <= '0;
        end else begin
            ptr        <= next_ptr;
            latch      <= next_latch;
            pgm_sel    <= next_pgm_sel;
            cfg_sel    <= next_cfg_sel;
            erase_sel  <= next_erase_sel;
            permit     <= next_permit;
            start      <= next_start;
            abort_flag <= next_abort_flag;
            done_flag  <= next_done_flag;
            ulk        <= next_ulk;
            seq        <= next_seq;
            tmr        <= next_tmr;
        end
    end

    // ************************************************************
    // Array and holding registers
    // ************************************************************
    // No reset on the array: it models non-volatile content
    always_ff @(posedge ref_clk) begin
        if (seq == PFSA_RUN && bus.tbl_wr && !bus.ptr_load && !bus.abort_rst) begin
            hold[rd_addr[HOLD_SEL-1:0]] <= bus.tbl_wdata;
        end
        // Flash targets only when program space and not config space
        if (commit && pgm_sel && !cfg_sel) begin
            for (int i = 0; i < ROW_BYTES / 2; i++) begin
                if (erase_sel) begin
                    mem[{ptr[MEM_AW:ROW_LSB], 5'(i)}] <= {ERASED_BYTE, ERASED_BYTE};
                end else if (i < HOLD_N / 2) begin
                    mem[{ptr[MEM_AW:BLK_LSB], 2'(i)}] <= {hold[2*i+1], hold[2*i]};
                end
            end
        end
    end

    assign bus.flash_byte_pointer = ptr;
    assign bus.table_byte_latch   = latch;
    assign bus.start_program_bit  = start;
    assign bus.aborted_write_flag = abort_flag;
    assign bus.done_irq_flag      = done_flag;
    assign bus.core_stall         = (seq == PFSA_LONG_WRITE);

endmodule : pfsa_device

// [design/pfsa_core.sv]
// Processor-core end: turns user requests into table and control actions
`timescale 1ns/1ps
module pfsa_core
    import pfsa_pkg::*;
(
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    // Device side
    pfsa_if.core                         bus,
    // User requests, one-cycle pulses, refused while busy except clear-done and abort
    input  wire logic                    req_rd,
    input  wire logic                    req_wr,
    input  wire pfsa_pkg::pfsa_ptr_mode_e req_mode,
    input  wire logic [7:0]              req_wdata,
    input  wire logic                    req_load,
    input  wire logic [pfsa_pkg::PTR_W-1:0] req_addr,
    input  wire logic                    req_erase,
    input  wire logic                    req_program,
    input  wire logic                    req_clr_done,
    input  wire logic                    req_abort,
    // User status
    output logic                         busy,
    output logic [7:0]                   rd_data,
    output logic                         aborted,
    output logic                         done
);
    import pfsa_pkg::*;

    // ************************************************************
    // Launch sequence
    // ************************************************************
    typedef enum logic [2:0] {
        PFSA_C_IDLE, PFSA_C_CTRL, PFSA_C_K1, PFSA_C_K2, PFSA_C_GO, PFSA_C_WAIT
    } pfsa_cstate_e;

    pfsa_cstate_e cst, next_cst;
    logic         erase_op, next_erase_op;

    always_comb begin
        next_cst      = cst;
        next_erase_op = erase_op;
        case (cst)
            PFSA_C_IDLE: if (req_erase || req_program) begin
                next_cst      = PFSA_C_CTRL;
                next_erase_op = req_erase;
            end
            PFSA_C_CTRL: next_cst = PFSA_C_K1;
            PFSA_C_K1:   next_cst = PFSA_C_K2;
            PFSA_C_K2:   next_cst = PFSA_C_GO;
            PFSA_C_GO:   next_cst = PFSA_C_WAIT;
            PFSA_C_WAIT: if (!bus.core_stall) next_cst = PFSA_C_IDLE;
            default:     next_cst = PFSA_C_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cst      <= PFSA_C_IDLE;
            erase_op <= 1'b0;
        end else begin
            cst      <= next_cst;
            erase_op <= next_erase_op;
        end
    end

    wire idle = (cst == PFSA_C_IDLE) && !bus.core_stall;

    assign bus.tbl_rd               = idle && req_rd;
    assign bus.tbl_wr               = idle && req_wr;
    assign bus.ptr_mode             = req_mode;
    assign bus.ptr_load             = idle && req_load;
    assign bus.ptr_load_val         = req_addr;
    assign bus.tbl_wdata            = req_wdata;
    assign bus.ctrl_wr              = (cst == PFSA_C_CTRL);
    assign bus.program_space_select = 1'b1;
    assign bus.config_space_select  = 1'b0;
    assign bus.row_erase_select     = erase_op;
    assign bus.write_permit         = 1'b1;
    assign bus.unlock_wr            = (cst == PFSA_C_K1) || (cst == PFSA_C_K2);
    assign bus.unlock_data          = (cst == PFSA_C_K1) ? UNLOCK_FIRST : UNLOCK_SECOND;
    assign bus.start_set            = (cst == PFSA_C_GO);
    assign bus.done_irq_clr         = req_clr_done;
    assign bus.abort_rst            = req_abort;

    assign busy    = !idle;
    assign rd_data = bus.table_byte_latch;
    assign aborted = bus.aborted_write_flag;
    assign done    = bus.done_irq_flag;

endmodule : pfsa_core

// [test/pfsa_asserts.sv]
// Concurrent checks on the interface between core end and flash sequencer end
`timescale 1ns/1ps
module pfsa_asserts #(
    parameter int LONG_CYCLES = 8
) (
    // Clock and reset
    input wire logic                       ref_clk,
    input wire logic                       rst,
    // Core requests
    input wire logic                       tbl_rd,
    input wire logic                       tbl_wr,
    input wire pfsa_pkg::pfsa_ptr_mode_e   ptr_mode,
    input wire logic                       ptr_load,
    input wire logic                       unlock_wr,
    input wire logic [7:0]                 unlock_data,
    input wire logic                       start_set,
    input wire logic                       abort_rst,
    // Device state
    input wire logic [pfsa_pkg::PTR_W-1:0] flash_byte_pointer,
    input wire logic [7:0]                 table_byte_latch,
    input wire logic                       start_program_bit,
    input wire logic                       aborted_write_flag,
    input wire logic                       done_irq_flag,
    input wire logic                       core_stall
);
    import pfsa_pkg::*;
    logic [31:0] stall_cnt;
    logic [31:0] next_stall_cnt;
    logic        tbl_step;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ************************************************************
    // Stall length counter, too long for a repetition
    // ************************************************************
    always_comb begin
        next_stall_cnt = core_stall ? stall_cnt + 32'h1 : 32'h0;
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stall_cnt <= 32'h0;
        end else begin
            stall_cnt <= next_stall_cnt;
        end
    end
    assign tbl_step = (tbl_rd || tbl_wr) && !ptr_load && !core_stall && !abort_rst;
    // ************************************************************
    // Assertions
    // ************************************************************
    chk_start_unlock: assert property (
        $rose(start_program_bit) |-> $past(start_set) && $past(unlock_wr, 2)
        && $past(unlock_data, 2) == UNLOCK_SECOND && $past(unlock_wr, 3)
        && $past(unlock_data, 3) == UNLOCK_FIRST) else $error("start without unlock");
    chk_start_refused: assert property (
        start_set && !start_program_bit && !($past(unlock_wr) && !$past(abort_rst)
        && $past(unlock_data) == UNLOCK_SECOND && $past(unlock_wr, 2) && !$past(abort_rst, 2)
        && $past(unlock_data, 2) == UNLOCK_FIRST) |=> !start_program_bit)
        else $error("start taken without fresh unlock");
    chk_stall_begin: assert property (
        $rose(core_stall) |-> $past(start_set) && start_program_bit) else $error("bad stall");
    chk_stall_len: assert property (
        $fell(core_stall) && !$past(abort_rst) |-> stall_cnt == LONG_CYCLES)
        else $error("long write length wrong");
    chk_stall_bound: assert property (
        core_stall |-> stall_cnt < LONG_CYCLES) else $error("long write overran");
    chk_done_end: assert property (
        $fell(core_stall) && !$past(abort_rst) |-> done_irq_flag && $fell(start_program_bit))
        else $error("completion flags wrong");
    chk_abort_flag: assert property (
        abort_rst && core_stall |=> aborted_write_flag && !core_stall)
        else $error("abort not flagged");
    chk_latch_src: assert property (
        $changed(table_byte_latch) |-> $past(tbl_rd) || $past(abort_rst))
        else $error("latch changed without read");
    chk_ptr_cfg: assert property (
        tbl_step |=> flash_byte_pointer[CFG_BIT] == $past(flash_byte_pointer[CFG_BIT]))
        else $error("config bit stepped");
    chk_ptr_inc: assert property (
        tbl_step && (ptr_mode == PFSA_PTR_POST_INC || ptr_mode == PFSA_PTR_PRE_INC)
        |=> flash_byte_pointer[20:0] == $past(flash_byte_pointer[20:0]) + 21'h1)
        else $error("pointer increment wrong");
    cov_done: cover property ($fell(core_stall) && done_irq_flag);
    cov_abort: cover property ($rose(aborted_write_flag));
    cov_pre_inc: cover property (tbl_wr && ptr_mode == PFSA_PTR_PRE_INC);
    cov_post_dec: cover property (tbl_rd && ptr_mode == PFSA_PTR_POST_DEC);
endmodule : pfsa_asserts

// [test/tb_program_flash_self_access.sv]
// Self-checking bench: core end and flash sequencer end joined by the interface
`timescale 1ns/1ps
module tb_program_flash_self_access;
    import pfsa_pkg::*;
    // Short long-write keeps the run brief
    localparam int LC = 8;
    logic             ref_clk;
    logic             rst;
    logic             req_rd, req_wr, req_load, req_erase, req_program, req_clr_done, req_abort;
    pfsa_ptr_mode_e   req_mode;
    logic [7:0]       req_wdata;
    logic [PTR_W-1:0] req_addr;
    logic             busy, aborted, done;
    logic [7:0]       rd_data;
    int               fail_count;
    int               num_checks;
    pfsa_if pif ();
    pfsa_device #(.LONG_CYCLES(LC)) pfsa_device_inst (.ref_clk(ref_clk), .rst(rst),
        .bus(pif.device));
    pfsa_core pfsa_core_inst (.ref_clk(ref_clk), .rst(rst), .bus(pif.core), .req_rd(req_rd),
        .req_wr(req_wr), .req_mode(req_mode), .req_wdata(req_wdata), .req_load(req_load),
        .req_addr(req_addr), .req_erase(req_erase), .req_program(req_program),
        .req_clr_done(req_clr_done), .req_abort(req_abort), .busy(busy), .rd_data(rd_data),
        .aborted(aborted), .done(done));
    pfsa_asserts #(.LONG_CYCLES(LC)) pfsa_asserts_inst (.ref_clk(ref_clk), .rst(rst),
        .tbl_rd(pif.tbl_rd), .tbl_wr(pif.tbl_wr), .ptr_mode(pif.ptr_mode),
        .ptr_load(pif.ptr_load), .unlock_wr(pif.unlock_wr), .unlock_data(pif.unlock_data),
        .start_set(pif.start_set), .abort_rst(pif.abort_rst),
        .flash_byte_pointer(pif.flash_byte_pointer), .table_byte_latch(pif.table_byte_latch),
        .start_program_bit(pif.start_program_bit), .aborted_write_flag(pif.aborted_write_flag),
        .done_irq_flag(pif.done_irq_flag), .core_stall(pif.core_stall));
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input logic [PTR_W-1:0] seen, input logic [PTR_W-1:0] exp,
                       input string nm);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (2) @(posedge ref_clk);
        #1;
        while (busy !== 1'b0 && n < 200) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n >= 200) chk(1'b1, 1'b0, "idle wait");
    endtask : wait_idle
    // Requests are one-cycle pulses; the core refuses them while busy, except clear-done and abort
    task automatic go(ref logic r);
        r = 1'b1;
        @(posedge ref_clk);
        #1;
        r = 1'b0;
        wait_idle();
    endtask : go
    task automatic load(input logic [PTR_W-1:0] a);
        req_addr = a;
        go(req_load);
    endtask : load
    task automatic rd(input pfsa_ptr_mode_e m, input logic [7:0] e, input logic [PTR_W-1:0] p);
        req_mode = m;
        go(req_rd);
        chk(rd_data, e, "read byte");
        chk(pif.flash_byte_pointer, p, "pointer");
    endtask : rd
    task automatic wr(input pfsa_ptr_mode_e m, input logic [7:0] d);
        req_mode = m;
        req_wdata = d;
        go(req_wr);
    endtask : wr
    // Pre-increment from one below keeps the pointer inside the block
    // A nonzero ab gives the cycles after the request at which a core reset is sent
    task automatic prog(input logic [PTR_W-1:0] base, input logic [7:0] d, input int ab);
        load(base - 22'h1);
        for (int i = 0; i < 8; i++) wr(PFSA_PTR_PRE_INC, d + 8'(i));
        req_program = 1'b1;
        @(posedge ref_clk);
        #1;
        req_program = 1'b0;
        if (ab > 0) begin
            repeat (ab) @(posedge ref_clk);
            #1;
            go(req_abort);
        end else begin
            wait_idle();
        end
    endtask : prog
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    // ************************************************************
    // Clock, watchdog and test sequence
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        #200000;
        fail_count++;
        give_verdict();
    end
    initial begin
        fail_count = 0;
        num_checks = 0;
        rst = 1'b1;
        {req_rd, req_wr, req_load, req_erase, req_program, req_clr_done, req_abort} = 7'h0;
        req_mode = PFSA_PTR_KEEP;
        req_wdata = 8'h00;
        req_addr = 22'h0;
        repeat (2) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        chk(pif.flash_byte_pointer, 22'h0, "pointer reset");
        chk({aborted, done, busy}, 3'h0, "status reset");
        load(22'h140);
        go(req_erase);
        chk(done, 1'b1, "done flag");
        go(req_clr_done);
        chk(done, 1'b0, "done cleared");
        prog(22'h178, 8'h20, 1'b0);
        load(22'h17e);
        rd(PFSA_PTR_POST_INC, 8'h26, 22'h17f);
        rd(PFSA_PTR_POST_INC, 8'h27, 22'h180);
        load(22'h1bf);
        go(req_erase);
        prog(22'h180, 8'h10, 1'b0);
        // Low six pointer bits nonzero on purpose; the whole row must still go
        load(22'h16a);
        go(req_erase);
        load(22'h140);
        rd(PFSA_PTR_KEEP, 8'hff, 22'h140);
        load(22'h17f);
        rd(PFSA_PTR_POST_INC, 8'hff, 22'h180);
        load(22'h180);
        for (int i = 0; i < 8; i++) rd(PFSA_PTR_POST_INC, 8'h10 + 8'(i), 22'h181 + 22'(i));
        rd(PFSA_PTR_POST_DEC, 8'hff, 22'h187);
        rd(PFSA_PTR_KEEP, 8'h17, 22'h187);
        rd(PFSA_PTR_PRE_INC, 8'hff, 22'h188);
        load(22'h180);
        wr(PFSA_PTR_KEEP, 8'h99);
        rd(PFSA_PTR_KEEP, 8'h10, 22'h180);
        load(22'h3fffff);
        rd(PFSA_PTR_POST_INC, 8'h00, 22'h200000);
        rd(PFSA_PTR_POST_DEC, 8'h00, 22'h3fffff);
        // Core reset lands on the second unlock write, so the start must be ignored
        go(req_clr_done);
        prog(22'h198, 8'h50, 2);
        chk(done, 1'b0, "refused start done");
        chk(aborted, 1'b0, "refused start abort");
        load(22'h198);
        rd(PFSA_PTR_KEEP, 8'hff, 22'h198);
        prog(22'h188, 8'h40, 6);
        chk(aborted, 1'b1, "abort flag");
        chk(pif.flash_byte_pointer, 22'h0, "pointer after abort");
        load(22'h18a);
        rd(PFSA_PTR_KEEP, 8'hff, 22'h18a);
        give_verdict();
    end
endmodule : tb_program_flash_self_access
